// file: design/dtbr_defines.svh
// Constants for the dual ten-bit bus register
`ifndef DTBR_DEFINES_SVH
`define DTBR_DEFINES_SVH
`define DTBR_SECTION_W 10
`define DTBR_SECTIONS 2
`define DTBR_LOWER 0
`define DTBR_UPPER 1
`define DTBR_OE_OFF_N 1'h1
`define DTBR_STROBE_IDLE 1'h0
`endif

// file: design/dtbr_pkg.sv
// Types shared by the dual ten-bit bus register
package dtbr_pkg;
	`include "dtbr_defines.svh"
	// One section's worth of bits
	typedef logic [`DTBR_SECTION_W-1:0] dtbr_word_t;
	// Per-section control bits, index 0 is the lower half
	typedef logic [`DTBR_SECTIONS-1:0] dtbr_sect_t;
endpackage

// file: design/dtbr_top.sv
// Dual ten-bit edge-captured bus register with per-half strobe and drive enable
//
// Overview of operation
// - Strobe rising edge loads each section's data
// - Two ten-bit halves, combinable into twenty bits
// - Each half has own strobe and enable
// - Enable low drives stored bits, high floats
// - Enable never touches stored contents
// - No rising edge means stored bits hold
// - Undriven data input keeps last level
`timescale 1ns/1ps
`include "dtbr_defines.svh"
module dtbr_top (
	input wire logic core_clk_i, // 250 MHz core clock
	input wire logic nrst_i, // Async reset, clears strobe and enable synchronisers and check flags only, not the data path
	input wire logic lower_half_strobe_i, // Capture strobe pin, lower half
	input wire logic upper_half_strobe_i, // Capture strobe pin, upper half
	input wire logic lower_half_drive_enable_n_i, // Drive enable pin, lower half
	input wire logic upper_half_drive_enable_n_i, // Drive enable pin, upper half
	input wire dtbr_pkg::dtbr_word_t lower_data_i, // Data pins, lower half
	input wire dtbr_pkg::dtbr_word_t upper_data_i, // Data pins, upper half
	input wire dtbr_pkg::dtbr_word_t lower_data_driven_i, // High where a pin is actively driven
	input wire dtbr_pkg::dtbr_word_t upper_data_driven_i, // High where a pin is actively driven
	output logic [`DTBR_SECTION_W-1:0] lower_q_o, // Stored bits, lower half
	output logic [`DTBR_SECTION_W-1:0] upper_q_o, // Stored bits, upper half
	output logic [`DTBR_SECTION_W-1:0] lower_q_oe_o, // Per-pin drive enable, lower half
	output logic [`DTBR_SECTION_W-1:0] upper_q_oe_o // Per-pin drive enable, upper half
);
	import dtbr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Pin gathering: both halves are handled by index so they share one body
	dtbr_sect_t strobe_pin; // Raw strobe pins
	dtbr_sect_t oe_n_pin; // Raw enable pins
	dtbr_word_t data_pin [`DTBR_SECTIONS]; // Raw data pins
	dtbr_word_t drv_pin [`DTBR_SECTIONS]; // Raw drive-present flags

	assign strobe_pin = {upper_half_strobe_i, lower_half_strobe_i};
	assign oe_n_pin = {upper_half_drive_enable_n_i, lower_half_drive_enable_n_i};
	assign data_pin[`DTBR_LOWER] = lower_data_i;
	assign data_pin[`DTBR_UPPER] = upper_data_i;
	assign drv_pin[`DTBR_LOWER] = lower_data_driven_i;
	assign drv_pin[`DTBR_UPPER] = upper_data_driven_i;

	////////////////////////////////////////////////////////////////////////////
	// Control synchronisers with a third stage for the edge detector
	// Limitation: a strobe that is high or low for under one core cycle may be missed
	// A capture lands three core edges after the pin rises; bus users must allow for that
	dtbr_sect_t strobe_s1_ff, strobe_s2_ff, strobe_s3_ff; // Strobe chain
	dtbr_sect_t oe_n_s1_ff, oe_n_s2_ff; // Enable chain
	dtbr_sect_t nxt_strobe_s1, nxt_strobe_s2, nxt_strobe_s3;
	dtbr_sect_t nxt_oe_n_s1, nxt_oe_n_s2;
	dtbr_sect_t cap_edge; // One-cycle pulse on a strobe rising edge

	// Next values of the control chains; stage one feeds only stage two
	always_comb begin
		nxt_strobe_s1 = strobe_pin;
		nxt_strobe_s2 = strobe_s1_ff;
		nxt_strobe_s3 = strobe_s2_ff;
		nxt_oe_n_s1 = oe_n_pin;
		nxt_oe_n_s2 = oe_n_s1_ff;
	end

	// Reset to idle strobe and floating outputs so nothing fights the bus early
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strobe_s1_ff <= {`DTBR_SECTIONS{`DTBR_STROBE_IDLE}};
			strobe_s2_ff <= {`DTBR_SECTIONS{`DTBR_STROBE_IDLE}};
			strobe_s3_ff <= {`DTBR_SECTIONS{`DTBR_STROBE_IDLE}};
			oe_n_s1_ff <= {`DTBR_SECTIONS{`DTBR_OE_OFF_N}};
			oe_n_s2_ff <= {`DTBR_SECTIONS{`DTBR_OE_OFF_N}};
		end else begin
			strobe_s1_ff <= nxt_strobe_s1;
			strobe_s2_ff <= nxt_strobe_s2;
			strobe_s3_ff <= nxt_strobe_s3;
			oe_n_s1_ff <= nxt_oe_n_s1;
			oe_n_s2_ff <= nxt_oe_n_s2;
		end
	end

	// Rising edge of each half's own strobe, never the other half's
	assign cap_edge = strobe_s2_ff & ~strobe_s3_ff;

	////////////////////////////////////////////////////////////////////////////
	// Data path per section: synchroniser, keeper, capture register
	// Each data bit is synchronised on its own; it lines up with the strobe only if the
	// data stands still around the strobe rise, as a setup and hold window would demand
	dtbr_word_t data_s1_ff [`DTBR_SECTIONS]; // Data chain stage one
	dtbr_word_t data_s2_ff [`DTBR_SECTIONS]; // Data chain stage two
	dtbr_word_t drv_s1_ff [`DTBR_SECTIONS]; // Drive flag stage one
	dtbr_word_t drv_s2_ff [`DTBR_SECTIONS]; // Drive flag stage two
	dtbr_word_t keep_ff [`DTBR_SECTIONS]; // Last valid level seen per pin
	dtbr_word_t store_ff [`DTBR_SECTIONS]; // Captured contents
	dtbr_word_t nxt_data_s1 [`DTBR_SECTIONS];
	dtbr_word_t nxt_data_s2 [`DTBR_SECTIONS];
	dtbr_word_t nxt_drv_s1 [`DTBR_SECTIONS];
	dtbr_word_t nxt_drv_s2 [`DTBR_SECTIONS];
	dtbr_word_t nxt_keep [`DTBR_SECTIONS];
	dtbr_word_t nxt_store [`DTBR_SECTIONS];

	// Next values of the data path; the keeper level is what gets captured
	always_comb begin
		for (int s = 0; s < `DTBR_SECTIONS; s++) begin
			nxt_data_s1[s] = data_pin[s];
			nxt_data_s2[s] = data_s1_ff[s];
			nxt_drv_s1[s] = drv_pin[s];
			nxt_drv_s2[s] = drv_s1_ff[s];
			// Driven bits follow the pin, floating bits hold their last level
			nxt_keep[s] = (drv_s2_ff[s] & data_s2_ff[s]) | (~drv_s2_ff[s] & keep_ff[s]);
			if (cap_edge[s]) begin
				// Load the present level on this half's edge only
				nxt_store[s] = nxt_keep[s];
			end else begin
				// No edge: contents stay, whatever data or enable do
				nxt_store[s] = store_ff[s];
			end
		end
	end

	// Data flops carry no reset: contents are unknown until the first capture
	always_ff @(posedge core_clk_i) begin
		for (int s = 0; s < `DTBR_SECTIONS; s++) begin
			data_s1_ff[s] <= nxt_data_s1[s];
			data_s2_ff[s] <= nxt_data_s2[s];
			drv_s1_ff[s] <= nxt_drv_s1[s];
			drv_s2_ff[s] <= nxt_drv_s2[s];
			keep_ff[s] <= nxt_keep[s];
			store_ff[s] <= nxt_store[s];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output drive: enable gates only the drivers, never the storage
	// Drivers stay off through reset so the bus is never fought before the enable pin is seen
	assign lower_q_o = store_ff[`DTBR_LOWER];
	assign upper_q_o = store_ff[`DTBR_UPPER];
	assign lower_q_oe_o = {`DTBR_SECTION_W{~oe_n_s2_ff[`DTBR_LOWER]}};
	assign upper_q_oe_o = {`DTBR_SECTION_W{~oe_n_s2_ff[`DTBR_UPPER]}};

	////////////////////////////////////////////////////////////////////////////
	// Check helpers: a half's word is only comparable once it has been captured
	dtbr_sect_t seen_cap_ff; // Half has captured at least once since reset
	dtbr_sect_t nxt_seen_cap; // Next value of the captured flags

	// Sticky per half; the store itself has no reset, so before this the word is unknown
	always_comb begin
		nxt_seen_cap = seen_cap_ff | cap_edge;
	end

	// Cleared by reset, which costs hold coverage until the next strobe but never
	// lets an unknown word reach a stability check
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seen_cap_ff <= {`DTBR_SECTIONS{1'h0}};
		end else begin
			seen_cap_ff <= nxt_seen_cap;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking dtbr_cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	// Strobe pin rise gives the edge pulse two edges later and the stored word one edge after
	a_lower_capture_delay: assert property (
		$rose(lower_half_strobe_i)
		|-> ##2 cap_edge[`DTBR_LOWER] ##1 (lower_q_o == $past(nxt_keep[`DTBR_LOWER])))
		else $error("lower half did not capture after strobe edge");
	a_upper_capture_delay: assert property (
		$rose(upper_half_strobe_i)
		|-> ##2 cap_edge[`DTBR_UPPER] ##1 (upper_q_o == $past(nxt_keep[`DTBR_UPPER])))
		else $error("upper half did not capture after strobe edge");
	// Without an edge pulse the stored word stays; only checked once a word exists
	a_lower_hold_idle: assert property (
		!cap_edge[`DTBR_LOWER] && seen_cap_ff[`DTBR_LOWER] |=> $stable(lower_q_o))
		else $error("lower half changed without an edge");
	a_upper_hold_idle: assert property (
		!cap_edge[`DTBR_UPPER] && seen_cap_ff[`DTBR_UPPER] |=> $stable(upper_q_o))
		else $error("upper half changed without an edge");
	// One half's capture never touches the other half
	a_halves_independent: assert property (
		cap_edge[`DTBR_UPPER] && !cap_edge[`DTBR_LOWER] && seen_cap_ff[`DTBR_LOWER] |=> $stable(lower_q_o))
		else $error("upper strobe disturbed lower half");
	a_lower_leaves_upper: assert property (
		cap_edge[`DTBR_LOWER] && !cap_edge[`DTBR_UPPER] && seen_cap_ff[`DTBR_UPPER] |=> $stable(upper_q_o))
		else $error("lower strobe disturbed upper half");
	// Drivers follow the enable pin two edges late, through its synchroniser
	a_upper_enable_drive: assert property (
		$fell(upper_half_drive_enable_n_i) |-> ##2 (upper_q_oe_o == {`DTBR_SECTION_W{1'h1}}))
		else $error("upper drivers not on two cycles after enable");
	a_lower_disable_float: assert property (
		$rose(lower_half_drive_enable_n_i) |-> ##2 (lower_q_oe_o == {`DTBR_SECTION_W{1'h0}}))
		else $error("lower drivers not off two cycles after disable");
	a_enable_to_drive: assert property (
		$fell(lower_half_drive_enable_n_i) ##1 !lower_half_drive_enable_n_i
		|=> (lower_q_oe_o == {`DTBR_SECTION_W{1'h1}}))
		else $error("lower drivers not on two cycles after enable");
	a_disable_to_float: assert property (
		$rose(upper_half_drive_enable_n_i) ##1 upper_half_drive_enable_n_i
		|=> (upper_q_oe_o == {`DTBR_SECTION_W{1'h0}}))
		else $error("upper drivers not off two cycles after disable");
	// Capture goes on while the drivers are off
	a_upper_capture_float: assert property (
		cap_edge[`DTBR_UPPER] && oe_n_s2_ff[`DTBR_UPPER]
		|=> (upper_q_o == $past(nxt_keep[`DTBR_UPPER])))
		else $error("capture lost while upper drivers off");
	a_capture_while_float: assert property (
		cap_edge[`DTBR_LOWER] && oe_n_s2_ff[`DTBR_LOWER]
		|=> (lower_q_o == $past(nxt_keep[`DTBR_LOWER])))
		else $error("capture lost while lower drivers off");
	// A floating data pin keeps its last level in the keeper
	a_keeper_holds: assert property (
		!drv_s2_ff[`DTBR_LOWER][0] |=> (keep_ff[`DTBR_LOWER][0] == $past(keep_ff[`DTBR_LOWER][0])))
		else $error("keeper lost level on floating pin");

	// Main scenarios: plain, joint and floating captures, floating pin, drivers back on
	c_lower_capture: cover property (cap_edge[`DTBR_LOWER] ##1 !oe_n_s2_ff[`DTBR_LOWER]);
	c_lower_reenable: cover property ($fell(lower_half_drive_enable_n_i) ##2 !oe_n_s2_ff[`DTBR_LOWER]);
	c_both_capture: cover property (cap_edge == {`DTBR_SECTIONS{1'h1}});
	c_float_capture: cover property (cap_edge[`DTBR_UPPER] && oe_n_s2_ff[`DTBR_UPPER]);
	c_floating_pin: cover property (cap_edge[`DTBR_LOWER] && !drv_s2_ff[`DTBR_LOWER][0]);
endmodule

// file: sim/dtbr_bus_model.sv
// Shared downstream bus seen by one half of the register
`timescale 1ns/1ps
module dtbr_bus_model (
	input wire logic core_clk_i, // Core clock
	input wire dtbr_pkg::dtbr_word_t q_i, // Register outputs
	input wire dtbr_pkg::dtbr_word_t oe_i, // Per-pin drive enables
	output dtbr_pkg::dtbr_word_t bus_o // Resolved bus level
);
	import dtbr_pkg::*;
	dtbr_word_t last_ff; // Level seen last cycle
	// Released pins toggle each cycle, so a stale value never looks driven
	always_ff @(posedge core_clk_i) begin
		last_ff <= bus_o;
	end
	always_comb begin
		for (int i = 0; i < $bits(dtbr_word_t); i++) begin
			bus_o[i] = oe_i[i] ? q_i[i] : ~last_ff[i];
		end
	end
endmodule

// file: sim/tb_dtbr_top.sv
// Self-checking bench for the dual ten-bit bus register
`timescale 1ns/1ps
module tb_dtbr_top;
	import dtbr_pkg::*;
	logic clk = 1'h0, nrst_i = 1'h0, ls = 1'h0, us = 1'h0, loe_n = 1'h0, uoe_n = 1'h0;
	dtbr_word_t ld = 10'h000, ud = 10'h000, ldrv = 10'h3ff, udrv = 10'h3ff;
	dtbr_word_t lq, uq, loe, uoe, lbus;
	int n_errors = 0, num_checks = 0, cycles = 0;
	dtbr_top i_dtbr_top (.core_clk_i(clk), .nrst_i(nrst_i), .lower_half_strobe_i(ls), .upper_half_strobe_i(us),
		.lower_half_drive_enable_n_i(loe_n), .upper_half_drive_enable_n_i(uoe_n), .lower_data_i(ld),
		.upper_data_i(ud), .lower_data_driven_i(ldrv), .upper_data_driven_i(udrv), .lower_q_o(lq),
		.upper_q_o(uq), .lower_q_oe_o(loe), .upper_q_oe_o(uoe));
	dtbr_bus_model i_dtbr_bus_model (.core_clk_i(clk), .q_i(lq), .oe_i(loe), .bus_o(lbus));
	// 250 MHz clock
	always #2 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input dtbr_word_t exp, input dtbr_word_t act);
		num_checks++;
		if (act !== exp) begin
			n_errors++;
			$display("Error at %0t: expected %h got %h", $time, exp, act);
		end
	endtask
	// Strobe high two cycles, then low for six while the result settles
	task automatic pulse(input logic lo, input logic up, input dtbr_word_t l, input dtbr_word_t u);
		@(posedge clk);
		ld <= l;
		ud <= u;
		ls <= lo;
		us <= up;
		repeat (2) @(posedge clk);
		ls <= 1'h0;
		us <= 1'h0;
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic t_both();
		pulse(1'h1, 1'h1, 10'h2a5, 10'h15a);
		chk(10'h2a5, lq);
		chk(10'h15a, uq);
		chk(10'h3ff, loe);
		chk(10'h2a5, lbus);
	endtask
	task automatic t_indep();
		pulse(1'h1, 1'h0, 10'h0f0, 10'h333);
		chk(10'h0f0, lq);
		chk(10'h15a, uq);
	endtask
	task automatic t_hidden();
		@(posedge clk);
		uoe_n <= 1'h1;
		pulse(1'h0, 1'h1, 10'h000, 10'h3c3);
		chk(10'h000, uoe);
		chk(10'h3ff, loe);
		@(posedge clk);
		uoe_n <= 1'h0;
		repeat (4) @(posedge clk);
		#1;
		chk(10'h3c3, uq);
		chk(10'h3ff, uoe);
	endtask
	task automatic t_hold();
		@(posedge clk);
		ld <= 10'h111;
		ls <= 1'h1;
		repeat (4) @(posedge clk);
		ld <= 10'h1ee;
		repeat (6) @(posedge clk);
		#1;
		chk(10'h111, lq);
		@(posedge clk);
		ls <= 1'h0;
		repeat (6) @(posedge clk);
		#1;
		chk(10'h111, lq);
	endtask
	task automatic t_keeper();
		@(posedge clk);
		ldrv <= 10'h000;
		pulse(1'h1, 1'h0, 10'h000, 10'h000);
		chk(10'h1ee, lq);
		@(posedge clk);
		ldrv <= 10'h3ff;
	endtask
	// Lower drivers off while a new word is captured, then back on
	task automatic t_lower_float();
		@(posedge clk);
		loe_n <= 1'h1;
		pulse(1'h1, 1'h0, 10'h155, 10'h000);
		chk(10'h000, loe);
		chk(10'h3ff, uoe);
		chk(10'h155, lq);
		@(posedge clk);
		loe_n <= 1'h0;
		repeat (4) @(posedge clk);
		#1;
		chk(10'h3ff, loe);
		chk(10'h155, lbus);
	endtask
	// Mid-run reset floats the drivers but leaves the stored words alone
	task automatic t_reset_keeps();
		@(posedge clk);
		nrst_i <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
		chk(10'h000, loe);
		chk(10'h155, lq);
		chk(10'h3c3, uq);
		@(posedge clk);
		nrst_i <= 1'h1;
		repeat (3) @(posedge clk);
		#1;
		chk(10'h3ff, loe);
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		#1;
		chk(10'h000, loe);
		@(posedge clk);
		nrst_i <= 1'h1;
		repeat (3) @(posedge clk);
		t_both();
		t_indep();
		t_hidden();
		t_hold();
		t_keeper();
		t_lower_float();
		t_reset_keeps();
		report_and_stop();
	end
endmodule
